// [fms_pkg.sv]
`default_nettype none
package fms_pkg;
  // lane and vector geometry
  localparam int LANE_W      = 32;
  localparam int FULL_LANES  = 8;
  localparam int FLAG_W      = 5;
  // exception flag positions, same order in masks
  localparam int FLG_INV     = 0;
  localparam int FLG_DEN     = 1;
  localparam int FLG_OVF     = 2;
  localparam int FLG_UNF     = 3;
  localparam int FLG_INX     = 4;
  // single precision encoding
  localparam int EXP_BIAS    = 127;
  localparam int EXP_MAXB    = 255;
  localparam int FRAC_W      = 23;
  localparam int MIN_LSB_EXP = -149;
  localparam int PROD_PAD    = 28;
  localparam int ADD_PAD     = 52;
  localparam int WIN_W       = 80;
  localparam logic [31:0] QUIET_BIT   = 32'h0040_0000;
  localparam logic [31:0] DEF_QNAN    = 32'hFFC0_0000;
  localparam logic [30:0] INF_MAG     = 31'h7F80_0000;
  localparam logic [30:0] MAX_MAG     = 31'h7F7F_FFFF;
  // feature identification leaf
  localparam int FEATURE_BIT = 12;
  localparam logic [31:0] FEATURE_WORD = 32'h0000_1000;
  // operation forms: bit 1 negates the product, bit 0 negates the addend
  typedef enum logic [1:0] {
    FORM_ADD  = 2'h0,
    FORM_SUB  = 2'h1,
    FORM_NADD = 2'h2,
    FORM_NSUB = 2'h3
  } fms_form_t;
  // rounding modes
  typedef enum logic [1:0] {
    RM_NEAR = 2'h0,
    RM_DOWN = 2'h1,
    RM_UP   = 2'h2,
    RM_ZERO = 2'h3
  } fms_rm_t;
endpackage
`default_nettype wire

// [fms_unit.sv]
// Functional notes
// - like-signed infinities: infinity or default NaN
// - opposite infinities: NaN or signed infinity
// - zero plus zero signed by signs, rounding
// - zero product sign is xor of signs
// - product with zero addend rounded once
// - exact product plus addend, one rounding
// - exact cancellation: minus zero only rounding down
// - unmasked exception: no write, raise trap
// - read-only feature bit twelve set to one
// - full and half width vector operands
// - default NaN: sign one, top fraction one
// - invalid sets sticky vector invalid flag
// - first NaN quieted, invalid on signaling NaN
// - zero sum follows the zero-sign table
`timescale 1ns/10ps
`default_nettype none
module fms_unit #(
  parameter int LANES = fms_pkg::FULL_LANES
) (
  input  wire logic                              clk,
  input  wire logic                              resetn,
  input  wire logic                              op_valid,
  input  wire logic                              op_half,
  input  wire fms_pkg::fms_form_t                op_form,
  input  wire fms_pkg::fms_rm_t                  round_mode,
  input  wire logic [fms_pkg::FLAG_W-1:0]        exc_mask,
  input  wire logic [fms_pkg::FLAG_W-1:0]        flags_clear,
  input  wire logic [LANES*fms_pkg::LANE_W-1:0]  src_x,
  input  wire logic [LANES*fms_pkg::LANE_W-1:0]  src_y,
  input  wire logic [LANES*fms_pkg::LANE_W-1:0]  src_z,
  output logic                                   res_valid,
  output logic                                   res_write,
  output logic [LANES*fms_pkg::LANE_W-1:0]       res_data,
  output logic                                   trap_req,
  output logic [fms_pkg::FLAG_W-1:0]             vector_flags,
  output logic [31:0]                            feature_word
);
  import fms_pkg::*;

  // right shift keeping lost bits as a sticky lsb
  function automatic logic [WIN_W-1:0] fms_shr(input logic [WIN_W-1:0] v, input int d);
    logic [WIN_W-1:0] t;
    logic             st;
    t  = '0;
    st = 1'b0;
    if (d >= WIN_W) begin
      st = |v;
    end else begin
      st = |(v & ~({WIN_W{1'b1}} << d));
      t  = v >> d;
    end
    return {t[WIN_W-1:1], t[0] | st};
  endfunction

  // one lane: returns {flags, result}
  function automatic logic [FLAG_W+LANE_W-1:0] fms_lane(
    input logic [31:0] x, input logic [31:0] y, input logic [31:0] z,
    input logic negp, input logic negz, input fms_rm_t rm);
    // operand classes
    logic              nan_x;
    logic              nan_y;
    logic              nan_z;
    logic              inf_x;
    logic              inf_y;
    logic              inf_z;
    logic              zer_x;
    logic              zer_y;
    logic              zer_z;
    // exception sources and working signs
    logic              snan;
    logic              den;
    logic              ps;
    logic              zs;
    logic              rs;
    logic              sub;
    logic              grd;
    logic              lost;
    logic              inc;
    logic              ovf_inf;
    // significands and the exact alignment window
    logic [23:0]       mx;
    logic [23:0]       my;
    logic [23:0]       mz;
    logic [47:0]       mp;
    logic [WIN_W-1:0]  a;
    logic [WIN_W-1:0]  b;
    logic [WIN_W-1:0]  r;
    logic [24:0]       m;
    logic [FLAG_W-1:0] fl;
    logic [31:0]       res;
    // exponents and shift counts
    int                ex;
    int                ey;
    int                ez;
    int                fa;
    int                fb;
    int                fe;
    int                pos;
    int                sh;
    int                eb;
    // class decode per operand
    nan_x = (&x[30:23]) & (|x[22:0]);
    nan_y = (&y[30:23]) & (|y[22:0]);
    nan_z = (&z[30:23]) & (|z[22:0]);
    inf_x = (&x[30:23]) & ~(|x[22:0]);
    inf_y = (&y[30:23]) & ~(|y[22:0]);
    inf_z = (&z[30:23]) & ~(|z[22:0]);
    zer_x = ~(|x[30:0]);
    zer_y = ~(|y[30:0]);
    zer_z = ~(|z[30:0]);
    snan  = (nan_x & ~x[22]) | (nan_y & ~y[22]) | (nan_z & ~z[22]);
    den   = (~(|x[30:23]) & (|x[22:0])) | (~(|y[30:23]) & (|y[22:0]))
          | (~(|z[30:23]) & (|z[22:0]));
    ps    = x[31] ^ y[31] ^ negp;
    zs    = z[31] ^ negz;
    fl    = '0;
    res   = '0;
    mx    = {|x[30:23], x[22:0]};
    my    = {|y[30:23], y[22:0]};
    mz    = {|z[30:23], z[22:0]};
    mp    = mx * my;
    a     = '0;
    b     = '0;
    r     = '0;
    m     = '0;
    rs    = 1'b0;
    sub   = 1'b0;
    grd   = 1'b0;
    lost  = 1'b0;
    inc   = 1'b0;
    ovf_inf = 1'b0;
    ex = 0;
    ey = 0;
    ez = 0;
    fa = 0;
    fb = 0;
    fe = 0;
    pos = 0;
    sh = 0;
    eb = 0;
    if (nan_x | nan_y | nan_z) begin
      res = nan_x ? (x | QUIET_BIT) : (nan_y ? (y | QUIET_BIT) : (z | QUIET_BIT));
      fl[FLG_INV] = snan;
    end else begin
      fl[FLG_DEN] = den;
      if (inf_x | inf_y) begin
        if (zer_x | zer_y | (inf_z & (ps != zs))) begin
          res = DEF_QNAN;
          fl[FLG_INV] = 1'b1;
        end else begin
          res = {ps, INF_MAG};
        end
      end else if (inf_z) begin
        res = {zs, INF_MAG};
      end else if (zer_x | zer_y) begin
        if (zer_z) begin
          res = {(ps == zs) ? ps : (rm == RM_DOWN), 31'h0};
        end else begin
          res = {zs, z[30:0]};
        end
      end else begin
        a  = {4'h0, mp, {PROD_PAD{1'b0}}};
        b  = {4'h0, mz, {ADD_PAD{1'b0}}};
        // denormals share the smallest biased exponent
        ex = (x[30:23] == 8'h0) ? 1 : int'(x[30:23]);
        ey = (y[30:23] == 8'h0) ? 1 : int'(y[30:23]);
        ez = (z[30:23] == 8'h0) ? 1 : int'(z[30:23]);
        // weight of the lsb of each window operand
        fa = ex + ey - 2 * EXP_BIAS - 2 * FRAC_W - PROD_PAD;
        fb = ez - EXP_BIAS - FRAC_W - ADD_PAD;
        if (fa >= fb) begin
          fe = fa;
          b  = fms_shr(b, fa - fb);
        end else begin
          fe = fb;
          a  = fms_shr(a, fb - fa);
        end
        sub = ps ^ zs;
        if (a >= b) begin
          r  = sub ? a - b : a + b;
          rs = ps;
        end else begin
          r  = sub ? b - a : a + b;
          rs = zs;
        end
        if (r == '0) begin
          res = {rm == RM_DOWN, 31'h0};
        end else begin
          for (int i = 0; i < WIN_W; i++) begin
            if (r[i]) pos = i;
          end
          sh = pos - FRAC_W;
          if (sh < MIN_LSB_EXP - fe) sh = MIN_LSB_EXP - fe;
          if (sh <= 0) begin
            m = 25'(r << (-sh));
          end else if (sh > WIN_W) begin
            lost = 1'b1;
          end else begin
            m    = 25'(r >> sh);
            grd  = r[sh-1];
            lost = |(r & ~({WIN_W{1'b1}} << (sh - 1)));
          end
          eb = fe + sh + FRAC_W + EXP_BIAS;
          case (rm)
            RM_NEAR: inc = grd & (lost | m[0]);
            RM_UP:   inc = ~rs & (grd | lost);
            RM_DOWN: inc = rs & (grd | lost);
            default: inc = 1'b0;
          endcase
          m = m + {24'h0, inc};
          if (m[24]) begin
            m  = m >> 1;
            eb = eb + 1;
          end
          fl[FLG_INX] = grd | lost;
          fl[FLG_UNF] = (fe + pos + EXP_BIAS < 1) & (grd | lost);
          ovf_inf = (rm == RM_NEAR) | ((rm == RM_UP) & ~rs) | ((rm == RM_DOWN) & rs);
          if (eb >= EXP_MAXB) begin
            // bounded exponent: overflow to infinity or largest finite
            fl[FLG_OVF] = 1'b1;
            fl[FLG_INX] = 1'b1;
            res = {rs, ovf_inf ? INF_MAG : MAX_MAG};
          end else begin
            res = {rs, m[23] ? 8'(eb) : 8'h0, m[22:0]};
          end
        end
      end
    end
    return {fl, res};
  endfunction

  logic [FLAG_W+LANE_W-1:0] lane_out [LANES];
  logic [LANES*LANE_W-1:0]  next_res;
  logic [FLAG_W-1:0]        next_exc;
  logic                     unmasked;

  // one lane per element of the wide vector
  generate
    for (genvar g = 0; g < LANES; g++) begin : g_lane
      assign lane_out[g] = fms_lane(src_x[g*LANE_W +: LANE_W], src_y[g*LANE_W +: LANE_W],
                                    src_z[g*LANE_W +: LANE_W], op_form[1], op_form[0],
                                    round_mode);
    end
  endgenerate

  // half width clears upper lanes and ignores their flags
  always_comb begin
    next_res = '0;
    next_exc = '0;
    for (int i = 0; i < LANES; i++) begin
      if (!op_half || i < LANES / 2) begin
        next_res[i*LANE_W +: LANE_W] = lane_out[i][LANE_W-1:0];
        next_exc = next_exc | lane_out[i][FLAG_W+LANE_W-1:LANE_W];
      end
    end
    unmasked = |(next_exc & ~exc_mask);
  end

  // result write suppressed on unmasked exception
  always_ff @(posedge clk) begin
    if (!resetn) begin
      res_valid <= 1'b0;
      res_write <= 1'b0;
      res_data  <= '0;
      trap_req  <= 1'b0;
    end else begin
      res_valid <= op_valid;
      res_write <= op_valid & ~unmasked;
      trap_req  <= op_valid & unmasked;
      if (op_valid && !unmasked) res_data <= next_res;
    end
  end

  // sticky flags, new events win over clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vector_flags <= '0;
    end else begin
      vector_flags <= (vector_flags & ~flags_clear) | (op_valid ? next_exc : '0);
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      feature_word <= FEATURE_WORD;
    end else begin
      feature_word <= FEATURE_WORD;
    end
  end
endmodule
`default_nettype wire

// [fms_unit_props.sv]
`timescale 1ns/10ps
`default_nettype none
module fms_props #(
  parameter int LANES = fms_pkg::FULL_LANES
) (
  input wire logic                             clk,
  input wire logic                             resetn,
  input wire logic                             op_valid,
  input wire logic                             op_half,
  input wire logic [fms_pkg::FLAG_W-1:0]       exc_mask,
  input wire logic [fms_pkg::FLAG_W-1:0]       flags_clear,
  input wire logic [LANES*fms_pkg::LANE_W-1:0] src_x,
  input wire logic [LANES*fms_pkg::LANE_W-1:0] src_y,
  input wire logic [LANES*fms_pkg::LANE_W-1:0] src_z,
  input wire logic                             res_valid,
  input wire logic                             res_write,
  input wire logic [LANES*fms_pkg::LANE_W-1:0] res_data,
  input wire logic                             trap_req,
  input wire logic [fms_pkg::FLAG_W-1:0]       vector_flags,
  input wire logic [31:0]                      feature_word
);
  import fms_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic inf_zero;
  // lane 0 infinity times zero, addend not a nan
  assign inf_zero = op_valid && src_x[30:0] == INF_MAG && src_y[30:0] == '0
                    && !(src_z[30:23] == 8'hFF && src_z[22:0] != '0);
  property p_ans; op_valid |=> res_valid && (res_write ^ trap_req); endproperty
  a_ans: assert property (p_ans) else $error("bad answer");
  property p_stray; res_valid |-> $past(op_valid); endproperty
  a_stray: assert property (p_stray) else $error("stray answer");
  property p_keep; !res_write && $past(resetn) |-> $stable(res_data); endproperty
  a_keep: assert property (p_keep) else $error("data changed");
  property p_trap; inf_zero && !exc_mask[FLG_INV] |=> trap_req && !res_write; endproperty
  a_trap: assert property (p_trap) else $error("no trap");
  property p_feat; feature_word == FEATURE_WORD; endproperty
  a_feat: assert property (p_feat) else $error("bad feature");
  property p_half; op_valid && op_half |=> !res_write || res_data[LANES*32-1:128] == '0;
  endproperty
  a_half: assert property (p_half) else $error("upper lanes");
  property p_nan; inf_zero |=> vector_flags[FLG_INV] && (!res_write || res_data[31:0] == DEF_QNAN);
  endproperty
  a_nan: assert property (p_nan) else $error("bad nan");
  property p_stk; $past(resetn) |-> ($past(vector_flags) & ~$past(flags_clear) & ~vector_flags) == '0;
  endproperty
  a_stk: assert property (p_stk) else $error("flag lost");
  property p_qn;
    op_valid && src_x[30:23] == 8'hFF && src_x[22:0] != '0 && &exc_mask
      |=> res_data[31:0] == ($past(src_x[31:0]) | QUIET_BIT);
  endproperty
  a_qn: assert property (p_qn) else $error("bad quiet nan");
  c_half: cover property (op_valid && op_half);
  c_trap: cover property (trap_req);
  c_clr: cover property (flags_clear[FLG_INV] && vector_flags[FLG_INV]);
endmodule
bind fms_unit fms_props #(.LANES(LANES)) i_fms_props (.clk, .resetn, .op_valid, .op_half,
  .exc_mask, .flags_clear, .src_x, .src_y, .src_z, .res_valid, .res_write, .res_data, .trap_req,
  .vector_flags, .feature_word);
`default_nettype wire

// [fms_vreg.sv]
`timescale 1ns/10ps
`default_nettype none
module fms_vreg #(
  parameter int W = 256
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         res_write,
  input  wire logic [W-1:0] res_data,
  output logic [W-1:0]      dest,
  output int                writes
);
  // destination register, loaded only on write enable
  always_ff @(posedge clk) begin
    if (!resetn) begin
      writes <= 0;
    end else if (res_write) begin
      dest   <= res_data;
      writes <= writes + 1;
    end
  end
endmodule
`default_nettype wire

// [test_fused_multiply_add_specials.sv]
`timescale 1ns/10ps
`default_nettype none
module test_fused_multiply_add_specials;
  import fms_pkg::*;
  localparam logic [31:0] INF = 32'h7F800000, NINF = 32'hFF800000, ONE = 32'h3F800000;
  localparam logic [31:0] TWO = 32'h40000000, THREE = 32'h40400000;
  localparam logic [31:0] SAME [4] = '{INF, DEF_QNAN, DEF_QNAN, NINF};
  localparam logic [31:0] OPP [4] = '{DEF_QNAN, INF, NINF, DEF_QNAN};
  logic clk = 0, resetn = 0, op_valid = 0, op_half = 0, hf = 0, ps, zs;
  fms_form_t op_form = FORM_ADD;
  fms_rm_t round_mode = RM_NEAR;
  logic [4:0] exc_mask = 5'h1F, flags_clear = 5'h00, vector_flags;
  logic [255:0] src_x = '0, src_y = '0, src_z = '0, res_data, dest;
  logic res_valid, res_write, trap_req;
  logic [31:0] feature_word, rz;
  logic [1:0] f;
  logic [256:0] expq [$], got;
  int writes, nwr = 0, cyc = 0, num_errors = 0, checks_done = 0;
  fms_unit i_fms_unit (.clk, .resetn, .op_valid, .op_half, .op_form, .round_mode, .exc_mask,
    .flags_clear, .src_x, .src_y, .src_z, .res_valid, .res_write, .res_data, .trap_req,
    .vector_flags, .feature_word);
  fms_vreg i_fms_vreg (.clk, .resetn, .res_write, .res_data, .dest, .writes);
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [256:0] g, input logic [256:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    if (num_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // issue one operation and note the expected answer
  task automatic op(input logic [31:0] x, y, z, input logic [1:0] fm, input logic [31:0] e,
                    input logic [1:0] r = 2'h0, input logic [4:0] m = 5'h1F);
    @(negedge clk);
    op_valid = 1;
    op_half = hf;
    op_form = fms_form_t'(fm);
    round_mode = fms_rm_t'(r);
    exc_mask = m;
    src_x = {8{x}};
    src_y = {8{y}};
    src_z = {8{z}};
    expq.push_back({&m, hf ? {128'h0, {4{e}}} : {8{e}}});
    nwr += int'(&m);
  endtask
  task automatic idle;
    @(negedge clk);
    op_valid = 0;
  endtask
  // oldest note against each answer
  always @(negedge clk) begin
    if (res_valid === 1'b1) begin
      got = expq.pop_front();
      cmp(257'({res_write, trap_req}), 257'({got[256], !got[256]}));
      if (got[256]) cmp(257'(res_data), 257'(got[255:0]));
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    void'($urandom(24));
    repeat (3) @(posedge clk);
    @(negedge clk);
    resetn = 1;
    cmp(257'(feature_word), 257'(FEATURE_WORD));
    for (int i = 0; i < 4; i++) begin
      op(INF, ONE, INF, 2'(i), SAME[i]);
      op(INF, ONE, NINF, 2'(i), OPP[i]);
    end
    // signed zeros, every form, nearest and down
    for (int i = 0; i < 64; i++) begin
      ps = i[0] ^ i[1] ^ i[4];
      zs = i[2] ^ i[3];
      op({i[0], 31'h0}, {i[1], 31'h0}, {i[2], 31'h0}, 2'(i >> 3), {ps == zs ? ps : i[5], 31'h0},
         2'(i[5]));
    end
    for (int r = 0; r < 4; r++) begin
      op(TWO, THREE, 32'hC0C00000, 2'h0, {r == 1, 31'h0}, 2'(r));
    end
    op(TWO, THREE, 32'h0, 2'h2, 32'hC0C00000);
    op(TWO, THREE, ONE, 2'h0, 32'h40E00000);
    op(32'h3F800001, 32'h3F800001, 32'hBF800002, 2'h0, 32'h28800000);
    op(INF, TWO, ONE, 2'h3, NINF);
    op(TWO, THREE, INF, 2'h1, NINF);
    op(INF, 32'h0, ONE, 2'h0, DEF_QNAN);
    op(32'h7F800001, ONE, ONE, 2'h0, 32'h7FC00001);
    op(ONE, 32'hFF800005, 32'h7FC00009, 2'h0, 32'hFFC00005);
    op(ONE, ONE, 32'h7FC00009, 2'h1, 32'h7FC00009);
    op(INF, 32'h0, ONE, 2'h0, 32'h0, 2'h0, 5'h1E);
    op(32'h7F7FFFFF, TWO, 32'h0, 2'h0, 32'h0, 2'h0, 5'h1B);
    for (int i = 0; i < 8; i++) begin
      hf = 1'($urandom);
      rz = ($urandom & 32'hBFFFFFFF) | 32'h00800000;
      f = 2'($urandom);
      op($urandom & 32'h3FFFFFFF, {1'($urandom), 31'h0}, rz, f, rz ^ {f[0], 31'h0},
         2'($urandom));
    end
    hf = 0;
    idle;
    idle;
    cmp(257'({vector_flags[FLG_OVF], vector_flags[FLG_INX]}), 257'(2'h3));
    flags_clear = 5'h1F;
    idle;
    flags_clear = 5'h00;
    cmp(257'(vector_flags), 257'(0));
    op(INF, 32'h0, ONE, 2'h0, DEF_QNAN);
    idle;
    cmp(257'(vector_flags[FLG_INV]), 257'(1));
    idle;
    cmp(257'(writes), 257'(nwr));
    cmp(257'(dest), 257'({8{DEF_QNAN}}));
    summarize();
  end
endmodule
`default_nettype wire
